// *** shared/bsp_pkg.sv ***
/*
 * Shared constants of the boundary-scan test port: controller states,
 * instruction codes, register lengths and capture patterns.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package bsp_pkg;

    // Controller states, one-hot.
    typedef enum logic [15:0] {
        BSP_TLR   = 16'h0001,
        BSP_IDLE  = 16'h0002,
        BSP_SELDR = 16'h0004,
        BSP_CAPDR = 16'h0008,
        BSP_SHDR  = 16'h0010,
        BSP_EX1DR = 16'h0020,
        BSP_PAUDR = 16'h0040,
        BSP_EX2DR = 16'h0080,
        BSP_UPDR  = 16'h0100,
        BSP_SELIR = 16'h0200,
        BSP_CAPIR = 16'h0400,
        BSP_SHIR  = 16'h0800,
        BSP_EX1IR = 16'h1000,
        BSP_PAUIR = 16'h2000,
        BSP_EX2IR = 16'h4000,
        BSP_UPIR  = 16'h8000
    } bsp_state_e;

    localparam int unsigned   BSP_IR_W       = 4;
    localparam int unsigned   BSP_DR_W       = 32;
    localparam int unsigned   BSP_LEN_W      = 6;

    // Instruction codes.
    localparam logic [3:0]    BSP_INS_EXTEST = 4'h0;
    localparam logic [3:0]    BSP_INS_IDCODE = 4'h1;
    localparam logic [3:0]    BSP_INS_STATUS = 4'h2;
    localparam logic [3:0]    BSP_INS_BYPASS = 4'hF;

    // Instruction register capture pattern and reset instruction.
    localparam logic [3:0]    BSP_IR_CAPTURE = 4'h1;
    localparam logic [3:0]    BSP_IR_RESET   = BSP_INS_IDCODE;

    // Data register lengths, in bits.
    localparam logic [5:0]    BSP_LEN_BYPASS = 6'h01;
    localparam logic [5:0]    BSP_LEN_IDCODE = 6'h20;
    localparam logic [5:0]    BSP_LEN_STATUS = 6'h02;

    // Field positions of the status capture word.
    localparam int unsigned   BSP_ST_FAIL    = 0;
    localparam int unsigned   BSP_ST_ROUTE   = 1;

    // Identification word; the value is arbitrary.
    localparam logic [31:0]   BSP_IDCODE_DEF = 32'h0000_1235;

endpackage

// *** logic/bsp_sync.sv ***
/*
 * Two-flop level synchroniser for two bits into the test clock domain.
 * Assumes the inputs are levels that stay put for several test clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module bsp_sync
(
    // Destination clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Level in and synchronised level out.
    input  wire logic [1:0] d_i,
    output logic      [1:0] q_o
);

    logic [1:0] meta_r;
    logic [1:0] meta_nxt;
    logic [1:0] q_r;
    logic [1:0] q_nxt;

    always_comb
    begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    // The first stage feeds the second stage only.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= 2'h0;
            q_r    <= 2'h0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule

`default_nettype wire

// *** logic/bsp_tap_top.sv ***
/*
 * Boundary-scan test access port: controller, instruction register,
 * bypass, identification and status data registers, and the scan output
 * that may also carry the selected input clock fail flag.
 * Assumes the tester drives the test clock, mode select, data in and
 * test reset, and that the fail level and routing bit come from logic
 * on the master clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bsp_tap_top
(
    // Master clock side.
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_fail_i,
    input  wire logic       loss_flag_route_to_scan_out_i,
    // Test port.
    input  wire logic       tck_i,
    input  wire logic       trst_n_i,
    input  wire logic       tms_i,
    input  wire logic       tdi_i,
    output logic            tdo_o,
    output logic            tdo_oe_o
);
    import bsp_pkg::*;

    // Master clock side registers.
    logic                   fail_m_r;
    logic                   fail_m_nxt;
    logic                   route_m_r;
    logic                   route_m_nxt;

    always_comb
    begin
        fail_m_nxt  = clk_fail_i;
        route_m_nxt = loss_flag_route_to_scan_out_i;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            fail_m_r  <= 1'b0;
            route_m_r <= 1'b0;
        end
        else
        begin
            fail_m_r  <= fail_m_nxt;
            route_m_r <= route_m_nxt;
        end
    end

    // Levels cross into the test clock domain.
    logic [1:0]             lvl_t;
    logic                   fail_t;
    logic                   route_t;

    bsp_sync u_sync
    (
        .clk_i   (tck_i),
        .rst_n_i (trst_n_i),
        .d_i     ({route_m_r, fail_m_r}),
        .q_o     (lvl_t)
    );

    assign fail_t  = lvl_t[0];
    assign route_t = lvl_t[1];

    function automatic logic [5:0] dr_len(input logic [3:0] ins);
        begin
            unique case (ins)
                BSP_INS_IDCODE: dr_len = BSP_LEN_IDCODE;
                BSP_INS_STATUS: dr_len = BSP_LEN_STATUS;
                default:        dr_len = BSP_LEN_BYPASS;
            endcase
        end
    endfunction

    // Controller.
    bsp_state_e             state_r;
    bsp_state_e             state_nxt;

    always_comb
    begin
        unique case (state_r)
            BSP_TLR:   state_nxt = tms_i ? BSP_TLR   : BSP_IDLE;
            BSP_IDLE:  state_nxt = tms_i ? BSP_SELDR : BSP_IDLE;
            BSP_SELDR: state_nxt = tms_i ? BSP_SELIR : BSP_CAPDR;
            BSP_CAPDR: state_nxt = tms_i ? BSP_EX1DR : BSP_SHDR;
            BSP_SHDR:  state_nxt = tms_i ? BSP_EX1DR : BSP_SHDR;
            BSP_EX1DR: state_nxt = tms_i ? BSP_UPDR  : BSP_PAUDR;
            BSP_PAUDR: state_nxt = tms_i ? BSP_EX2DR : BSP_PAUDR;
            BSP_EX2DR: state_nxt = tms_i ? BSP_UPDR  : BSP_SHDR;
            BSP_UPDR:  state_nxt = tms_i ? BSP_SELDR : BSP_IDLE;
            BSP_SELIR: state_nxt = tms_i ? BSP_TLR   : BSP_CAPIR;
            BSP_CAPIR: state_nxt = tms_i ? BSP_EX1IR : BSP_SHIR;
            BSP_SHIR:  state_nxt = tms_i ? BSP_EX1IR : BSP_SHIR;
            BSP_EX1IR: state_nxt = tms_i ? BSP_UPIR  : BSP_PAUIR;
            BSP_PAUIR: state_nxt = tms_i ? BSP_EX2IR : BSP_PAUIR;
            BSP_EX2IR: state_nxt = tms_i ? BSP_UPIR  : BSP_SHIR;
            BSP_UPIR:  state_nxt = tms_i ? BSP_SELDR : BSP_IDLE;
            default:   state_nxt = BSP_TLR;
        endcase
    end

    // Instruction and data registers.
    logic [3:0]             ir_sr_r;
    logic [3:0]             ir_sr_nxt;
    logic [3:0]             ir_r;
    logic [3:0]             ir_nxt;
    logic [31:0]            dr_sr_r;
    logic [31:0]            dr_sr_nxt;
    logic [5:0]             len;

    always_comb
    begin
        ir_sr_nxt = ir_sr_r;
        ir_nxt    = ir_r;
        dr_sr_nxt = dr_sr_r;
        len       = dr_len(ir_r);
        unique case (state_r)
            BSP_TLR:
            begin
                ir_nxt = BSP_IR_RESET;
            end
            BSP_CAPIR:
            begin
                ir_sr_nxt = BSP_IR_CAPTURE;
            end
            BSP_SHIR:
            begin
                ir_sr_nxt = {tdi_i, ir_sr_r[3:1]};
            end
            BSP_UPIR:
            begin
                ir_nxt = ir_sr_r;
            end
            BSP_CAPDR:
            begin
                dr_sr_nxt = 32'h0000_0000;
                if (ir_r == BSP_INS_IDCODE)
                begin
                    dr_sr_nxt = BSP_IDCODE_DEF;
                end
                else if (ir_r == BSP_INS_STATUS)
                begin
                    dr_sr_nxt[BSP_ST_FAIL]  = fail_t;
                    dr_sr_nxt[BSP_ST_ROUTE] = route_t;
                end
            end
            BSP_SHDR:
            begin
                dr_sr_nxt = dr_sr_r >> 1;
                dr_sr_nxt[len[4:0] - 5'h01] = tdi_i;
            end
            default:
            begin
                dr_sr_nxt = dr_sr_r;
            end
        endcase
    end

    // All test logic moves only on test clock edges or on test reset, so it holds when idle.
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            state_r <= BSP_TLR;
            ir_sr_r <= 4'h0;
            ir_r    <= BSP_IR_RESET;
            dr_sr_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            ir_sr_r <= ir_sr_nxt;
            ir_r    <= ir_nxt;
            dr_sr_r <= dr_sr_nxt;
        end
    end

    // Scan output, updated on the falling edge.
    logic                   shifting;
    logic                   tdo_r;
    logic                   tdo_nxt;
    logic                   tdo_oe_r;
    logic                   tdo_oe_nxt;

    assign shifting = (state_r == BSP_SHDR) || (state_r == BSP_SHIR);

    always_comb
    begin
        tdo_nxt    = 1'b0;
        tdo_oe_nxt = 1'b0;
        if (state_r == BSP_SHIR)
        begin
            tdo_nxt    = ir_sr_r[0];
            tdo_oe_nxt = 1'b1;
        end
        else if (state_r == BSP_SHDR)
        begin
            tdo_nxt    = dr_sr_r[0];
            tdo_oe_nxt = 1'b1;
        end
        else if (route_t)
        begin
            tdo_nxt    = fail_t;
            tdo_oe_nxt = 1'b1;
        end
    end

    always_ff @(negedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end
        else
        begin
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo_o    = tdo_r;
    assign tdo_oe_o = tdo_oe_r;

    // Checks.
    a_reset_to_tlr: assert property (@(posedge mclk_i)
        !trst_n_i |-> (state_r == BSP_TLR) && !tdo_oe_o)
        else $error("Controller not in reset under test reset.");

    a_five_ones_tlr: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        tms_i [*5] |=> (state_r == BSP_TLR))
        else $error("Five mode select ones did not reach reset.");

    a_idle_stays: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_IDLE) && !tms_i |=> (state_r == BSP_IDLE))
        else $error("Idle left with mode select low.");

    a_ir_takes_tdi: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_SHIR) |=> (ir_sr_r[3] == $past(tdi_i)))
        else $error("Instruction shift missed data in.");

    a_dr_scan_out: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_SHDR) |-> tdo_oe_o && (tdo_o == dr_sr_r[0]))
        else $error("Scan output not set up before rising edge.");

    a_idle_clock_hold: assert property (@(posedge mclk_i)
        disable iff (!trst_n_i)
        !tck_i && $past(!tck_i) |-> $stable(state_r) && $stable(tdo_r))
        else $error("Test state moved with test clock parked low.");

    a_float_not_shift: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        !route_t && !shifting |-> !tdo_oe_o)
        else $error("Scan output driven outside shifting.");

    a_flag_on_out: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        route_t && !shifting |-> tdo_oe_o && (tdo_o == fail_t))
        else $error("Clock fail flag not on scan output.");

    a_ir_scan_only: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        !route_t && (state_r == BSP_SHIR) |-> (tdo_o == ir_sr_r[0]))
        else $error("Instruction scan output wrong.");

    a_sync_cleared: assert property (@(posedge mclk_i)
        !trst_n_i |-> (lvl_t == 2'h0) && (ir_r == BSP_IR_RESET) && !tdo_r)
        else $error("Test reset left state behind.");

    a_tlr_ir_reset: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_TLR) |=> (ir_r == BSP_IR_RESET))
        else $error("Reset state did not restore the instruction.");

    a_ir_capture_word: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_CAPIR) |=> (ir_sr_r == BSP_IR_CAPTURE))
        else $error("Instruction capture pattern wrong.");

    a_ir_update_load: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_UPIR) |=> (ir_r == $past(ir_sr_r)))
        else $error("Instruction not loaded on update.");

    a_bypass_capture: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_CAPDR) && (ir_r == BSP_INS_BYPASS) |=> !dr_sr_r[0])
        else $error("Bypass capture not zero.");

    a_dr_takes_tdi: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        (state_r == BSP_SHDR) && (ir_r == BSP_INS_IDCODE)
        |=> (dr_sr_r[31] == $past(tdi_i)))
        else $error("Data shift missed data in.");

    a_out_held_rise: assert property (@(posedge mclk_i)
        disable iff (!trst_n_i)
        $rose(tck_i) |-> $stable(tdo_r) && $stable(tdo_oe_r))
        else $error("Scan output moved on a rising edge.");

    a_shift_drives_out: assert property (@(posedge tck_i)
        disable iff (!trst_n_i)
        shifting |-> tdo_oe_o)
        else $error("Scan output not driven while shifting.");

endmodule

`default_nettype wire

// *** test/bsp_tester.sv ***
/*
 * Tester model for the test port: drives test clock, mode select and data in.
 * Assumes the bench calls step once per test clock; the clock rests low between calls.
 */
`timescale 1ns/1ps
`default_nettype none

module bsp_tester
(
    // Scan output seen from the port.
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    // Test port drive.
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One test clock of 125 ns; inputs held across the rising edge.
    task automatic step(input logic m, input logic d, output logic q, output logic oe,
                        output logic st);
        tms_o = m;
        tdi_o = d;
        #62.5;
        q = tdo_i;
        oe = tdo_oe_i;
        tck_o = 1'b1;
        #1 st = (tdo_i === q);
        #61.5 tck_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
/*
 * Top bench: random and corner scans through the test port.
 * Assumes the tester model makes the test clock in its own phase.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bsp_pkg::*;

    logic        mclk_i   = 1'b0;
    logic        rst_n_i  = 1'b0;
    logic        fail_i   = 1'b0;
    logic        route_i  = 1'b0;
    logic        trst_n_i = 1'b1;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_oe;
    int          fails    = 0;
    int          n_checks = 0;
    logic [31:0] got;
    logic [3:0]  codes [5] = '{BSP_INS_EXTEST, BSP_INS_IDCODE, BSP_INS_STATUS,
                               BSP_INS_BYPASS, 4'h5};

    always #10 mclk_i = ~mclk_i;

    bsp_tap_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_fail_i(fail_i),
        .loss_flag_route_to_scan_out_i(route_i), .tck_i(tck), .trst_n_i(trst_n_i),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe));

    bsp_tester tst (.tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    task automatic end_sim();
        $display("checks %0d, fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stp(input logic m, input logic d, output logic q, output logic oe);
        logic st;
        tst.step(m, d, q, oe, st);
        chk("tdo stable at rise", 32'h1, {31'h0, st});
    endtask

    // From idle: scan n bits of an instruction or data path, back to idle.
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] q);
        logic b;
        logic oe;
        q = '0;
        stp(1'b1, 1'b0, b, oe);
        if (ir)
            stp(1'b1, 1'b0, b, oe);
        stp(1'b0, 1'b0, b, oe);
        stp(1'b0, 1'b0, b, oe);
        for (int i = 0; i < n; i++)
        begin
            if (i == 1)
                repeat (300) @(posedge mclk_i);
            stp(i == n - 1, din[i], b, oe);
            q[i] = b;
            chk("oe while shifting", 32'h1, {31'h0, oe});
        end
        stp(1'b1, 1'b0, b, oe);
        stp(1'b0, 1'b0, b, oe);
    endtask

    task automatic idle_chk(input logic f, input logic r);
        logic b;
        logic oe;
        repeat (6) stp(1'b0, 1'b0, b, oe);
        chk("oe outside shift", {31'h0, r}, {31'h0, oe});
        if (r)
            chk("fail flag on tdo", {31'h0, f}, {31'h0, b});
    endtask

    function automatic logic [31:0] exp_dr(logic [3:0] c, logic [31:0] d, logic f, logic r);
        if (c == BSP_INS_IDCODE)
            return BSP_IDCODE_DEF;
        if (c == BSP_INS_STATUS)
            return {30'h0, r, f};
        return {24'h0, d[6:0], 1'b0};
    endfunction

    function automatic int dr_len(logic [3:0] c);
        return (c == BSP_INS_IDCODE) ? 32 : (c == BSP_INS_STATUS) ? 2 : 8;
    endfunction

    initial
    begin
        logic [31:0] d;
        logic [3:0]  c;
        logic        f;
        logic        r;
        logic        b;
        logic        oe;
        void'($urandom(32'hD4B4EF18));
        trst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #7.3;
        chk("oe in test reset", 32'h0, {31'h0, tdo_oe});
        @(posedge mclk_i);
        trst_n_i <= 1'b1;
        @(posedge mclk_i);
        stp(1'b0, 1'b0, b, oe);
        scan(1'b0, $urandom, 32, got);
        chk("reset instruction", BSP_IDCODE_DEF, got);
        for (int k = 0; k < 10; k++)
        begin
            c = codes[k % 5];
            f = 1'($urandom_range(1));
            r = (k >= 5);
            @(posedge mclk_i);
            fail_i <= f;
            route_i <= r;
            scan(1'b1, {28'h0, c}, 4, got);
            chk("ir capture", {28'h0, BSP_IR_CAPTURE}, got);
            d = $urandom;
            scan(1'b0, d, dr_len(c), got);
            chk("dr out", exp_dr(c, d, f, r), got);
            idle_chk(f, r);
        end
        scan(1'b1, {28'h0, BSP_INS_BYPASS}, 4, got);
        repeat (5) stp(1'b1, 1'b0, b, oe);
        stp(1'b0, 1'b0, b, oe);
        scan(1'b0, 32'h0, 32, got);
        chk("five ones to reset", BSP_IDCODE_DEF, got);
        stp(1'b1, 1'b0, b, oe);
        stp(1'b0, 1'b0, b, oe);
        stp(1'b0, 1'b0, b, oe);
        @(posedge mclk_i);
        trst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("oe on reset mid scan", 32'h0, {31'h0, tdo_oe});
        trst_n_i <= 1'b1;
        @(posedge mclk_i);
        stp(1'b0, 1'b0, b, oe);
        scan(1'b0, $urandom, 32, got);
        chk("instruction after reset", BSP_IDCODE_DEF, got);
        end_sim();
    end

    initial
    begin
        #1500000;
        fails++;
        end_sim();
    end
endmodule

`default_nettype wire
